// ### src/pdg_pkg.sv
// Package for the dual pulse generator: register map, control fields,
// mode codes and divider masks.
// Assumes a 32-bit Avalon-MM slave with byte addresses, one word per register.

package pdg_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [4:0] ADDR_CTRL    = 5'h00;
    localparam logic [4:0] ADDR_CMPA_LO = 5'h04;
    localparam logic [4:0] ADDR_CMPA_HI = 5'h08;
    localparam logic [4:0] ADDR_CMPB_LO = 5'h0C;
    localparam logic [4:0] ADDR_CMPB_HI = 5'h10;
    localparam logic [4:0] ADDR_STATUS  = 5'h14;

    // ------------------------------------------------------------------
    // Control register layout and reset values
    // ------------------------------------------------------------------
    localparam int         CTRL_MODE_LSB = 4;
    localparam int         CTRL_DIV_LSB  = 2;
    localparam logic [7:0] CTRL_RST      = 8'h00;
    localparam logic [7:0] CMP_RST       = 8'h00;

    // Status word layout
    localparam int STAT_OUT_A_BIT = 16;
    localparam int STAT_OUT_B_BIT = 17;

    // ------------------------------------------------------------------
    // Mode codes of the three-bit mode field
    // ------------------------------------------------------------------
    localparam logic [2:0] MODE_OFF    = 3'h0;
    localparam logic [2:0] MODE_SINGLE = 3'h1;
    localparam logic [2:0] MODE_TWIN8  = 3'h2;
    localparam logic [2:0] MODE_TWIN16 = 3'h3;
    localparam logic [2:0] MODE_NRZ    = 3'h4;
    localparam logic [2:0] MODE_DUAL8  = 3'h5;
    localparam logic [2:0] MODE_RZ     = 3'h6;

    // ------------------------------------------------------------------
    // Divider codes and prescaler masks (divide by mask + 1)
    // ------------------------------------------------------------------
    localparam logic [1:0] DIV_1  = 2'h0;
    localparam logic [1:0] DIV_4  = 2'h1;
    localparam logic [1:0] DIV_16 = 2'h2;
    localparam logic [1:0] DIV_64 = 2'h3;

    localparam logic [5:0] MASK_1  = 6'h00;
    localparam logic [5:0] MASK_4  = 6'h03;
    localparam logic [5:0] MASK_16 = 6'h0F;
    localparam logic [5:0] MASK_64 = 6'h3F;

    // Full-range counter limit of the fixed 16-bit and density modes
    localparam logic [15:0] CNT_FULL = 16'hFFFF;

endpackage

// ### src/pdg_pulse_gen.sv
// Dual pulse generator with pulse-width and sigma-delta density modes.
// Assumes an Avalon-MM master on clk, and pad logic that turns each
// output/enable pair into a port pin (enable low: pin is free for GPIO).
//
// Operation
// [RULE1] Disabled mode releases both outputs so the pins act as plain port pins.
// [RULE2] Single mode: second compare pair sets the waveform period.
// [RULE3] Single mode: first compare pair sets duty threshold of the one output.
// [RULE4] Twin 8-bit mode: second-pair low byte is the shared period.
// [RULE5] Twin 8-bit mode: output A falls when counter equals first-pair low byte.
// [RULE6] Twin 8-bit: B rises at second-pair high, falls at first-pair high.
// [RULE7] Twin 8-bit: zero in second-pair high makes both outputs start together.
// [RULE8] Twin 16-bit: counter runs full 16-bit range, each output own duty.
// [RULE9] Twin 16-bit: A high below first compare, low from equality to wrap.
// [RULE10] Twin 16-bit: B high below second compare, low from equality to wrap.
// [RULE11] Twin 16-bit: both outputs rise together when the counter wraps.
// [RULE12] NRZ density mode: fresh output level on every pulse clock.
// [RULE13] NRZ: each output high exactly compare clocks per 65536, spread evenly.
// [RULE14] Dual 8-bit: A period from second-pair low, B from second-pair high.
// [RULE15] Dual 8-bit: A duty from first-pair low, B from first-pair high.
// [RULE16] Dual 8-bit: both channels share one clock and one divider.
// [RULE17] RZ density mode: same density, each high clock is half high, half low.
// [RULE18] RZ: half-high then half-low pattern inside each pulse clock with a one.
// [RULE19] Software should pick divide-by-four for the RZ density mode.
// [RULE20] Mode field codes: off, single, twin8, twin16, NRZ, dual8, RZ, reserved.
// [RULE21] Any control register write resets the pulse counter.
// [RULE22] Sixteen-bit values: low byte held, high-byte write commits both.
// [RULE23] Divider field scales the pulse clock by 1, 4, 16 or 64.
// [RULE24] Variable-period modes count from zero to the period, then wrap.
// [RULE25] Density modes use a 16-bit accumulator per channel, carry is output.
//
// The Avalon-MM interface to the registers and the register addresses were decided locally.

`timescale 1ns/100ps

module pdg_pulse_gen #(
    parameter int ADDR_W = 5
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [31:0]       writedata,
    input  wire logic [3:0]        byteenable,
    output logic      [31:0]       readdata,
    output logic                   waitrequest,
    // Pulse output A pin
    output logic                   pulse_output_a_pin_o,
    output logic                   pulse_output_a_pin_oe,
    // Pulse output B pin
    output logic                   pulse_output_b_pin_o,
    output logic                   pulse_output_b_pin_oe
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    generate
        if (ADDR_W < 5) begin : g_addr_check
            $error("pdg_pulse_gen: ADDR_W must be at least 5");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------

    // Prescaler mask for a divider code
    function automatic logic [5:0] div_mask(input logic [1:0] code);
        logic [5:0] m;
        m = pdg_pkg::MASK_1;
        unique case (code)
            pdg_pkg::DIV_1:  m = pdg_pkg::MASK_1;
            pdg_pkg::DIV_4:  m = pdg_pkg::MASK_4;
            pdg_pkg::DIV_16: m = pdg_pkg::MASK_16;
            pdg_pkg::DIV_64: m = pdg_pkg::MASK_64;
        endcase
        return m;
    endfunction

    // Next value of a wrapping up-counter
    function automatic logic [15:0] count_next(input logic [15:0] cur,
                                               input logic [15:0] lim);
        return (cur == lim) ? 16'h0000 : cur + 16'h0001;
    endfunction

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0]  ctrl_q;
    logic [7:0]  cmpa_lo_q;
    logic [7:0]  cmpa_hi_q;
    logic [7:0]  cmpb_lo_q;
    logic [7:0]  cmpb_hi_q;
    logic [7:0]  hold_a_q;
    logic [7:0]  hold_b_q;
    logic [5:0]  pre_q;
    logic [15:0] cnt_q;
    logic [15:0] cnt2_q;
    logic [15:0] acc_a_q;
    logic [15:0] acc_b_q;
    logic        sd_a_q;
    logic        sd_b_q;
    logic        out_a_q;
    logic        out_b_q;
    logic        oe_a_q;
    logic        oe_b_q;
    logic        rd_ack_q;
    logic [31:0] readdata_q;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire logic [4:0] addr_w   = address[4:0];
    wire logic       wr_lane  = write & byteenable[0];
    wire logic       wr_ctrl  = wr_lane & (addr_w == pdg_pkg::ADDR_CTRL);
    wire logic       wr_a_lo  = wr_lane & (addr_w == pdg_pkg::ADDR_CMPA_LO);
    wire logic       wr_a_hi  = wr_lane & (addr_w == pdg_pkg::ADDR_CMPA_HI);
    wire logic       wr_b_lo  = wr_lane & (addr_w == pdg_pkg::ADDR_CMPB_LO);
    wire logic       wr_b_hi  = wr_lane & (addr_w == pdg_pkg::ADDR_CMPB_HI);
    wire logic [7:0] wr_byte  = writedata[7:0];
    wire logic       rd_start = read & ~rd_ack_q;

    // Writes never stall; reads take one wait cycle so data leave a flop
    assign waitrequest = rd_start;
    assign readdata    = readdata_q;

    // ------------------------------------------------------------------
    // Control field decode
    // ------------------------------------------------------------------
    wire logic [2:0] mode = ctrl_q[pdg_pkg::CTRL_MODE_LSB +: 3];   // RULE20
    wire logic [1:0] divc = ctrl_q[pdg_pkg::CTRL_DIV_LSB +: 2];

    wire logic m_single = (mode == pdg_pkg::MODE_SINGLE);
    wire logic m_twin8  = (mode == pdg_pkg::MODE_TWIN8);
    wire logic m_twin16 = (mode == pdg_pkg::MODE_TWIN16);
    wire logic m_nrz    = (mode == pdg_pkg::MODE_NRZ);
    wire logic m_dual8  = (mode == pdg_pkg::MODE_DUAL8);
    wire logic m_rz     = (mode == pdg_pkg::MODE_RZ);

    // Byte-wide modes take low bytes at once; no hidden holding needed
    wire logic m_byte   = m_twin8 | m_dual8;

    // Compare values as 16-bit words
    wire logic [15:0] cmp_a = {cmpa_hi_q, cmpa_lo_q};
    wire logic [15:0] cmp_b = {cmpb_hi_q, cmpb_lo_q};

    // ------------------------------------------------------------------
    // Pulse clock: prescaler tick
    // ------------------------------------------------------------------
    wire logic [5:0] mask   = div_mask(divc);                       // RULE23
    wire logic [5:0] phase  = pre_q & mask;
    wire logic       tick   = (phase == mask);
    wire logic [5:0] pre_d  = (wr_ctrl | tick) ? 6'h00 : pre_q + 6'h01;

    // Prescaler; restarting it with the counter keeps the first period whole
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pre_q <= 6'h00;
        end else begin
            pre_q <= pre_d;
        end
    end

    // ------------------------------------------------------------------
    // Main counter limit per mode
    // ------------------------------------------------------------------
    logic [15:0] limit;
    always_comb begin
        limit = pdg_pkg::CNT_FULL;
        if (m_single) begin
            limit = cmp_b;                                          // RULE2
        end else if (m_twin8 | m_dual8) begin
            limit = {8'h00, cmpb_lo_q};                             // RULE4 RULE14
        end else begin
            limit = pdg_pkg::CNT_FULL;                              // RULE8
        end
    end

    // Second counter serves channel B in the dual 8-bit mode only
    wire logic [15:0] limit2 = {8'h00, cmpb_hi_q};                  // RULE14

    // Both counters advance on the same tick of the shared divider
    wire logic [15:0] cnt_step  = count_next(cnt_q, limit);         // RULE24
    wire logic [15:0] cnt2_step = count_next(cnt2_q, limit2);       // RULE16
    wire logic [15:0] cnt_d     = wr_ctrl ? 16'h0000 :
                                  (tick ? cnt_step : cnt_q);        // RULE21
    wire logic [15:0] cnt2_d    = wr_ctrl ? 16'h0000 :
                                  (tick ? cnt2_step : cnt2_q);      // RULE21

    // Counters
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q  <= 16'h0000;
            cnt2_q <= 16'h0000;
        end else begin
            cnt_q  <= cnt_d;
            cnt2_q <= cnt2_d;
        end
    end

    // ------------------------------------------------------------------
    // Sigma-delta accumulators
    // ------------------------------------------------------------------
    // A first-order accumulator emits exactly cmp carries per 65536 adds,
    // and spreads them as evenly as a single integrator can.
    wire logic [16:0] sum_a = {1'b0, acc_a_q} + {1'b0, cmp_a};      // RULE25
    wire logic [16:0] sum_b = {1'b0, acc_b_q} + {1'b0, cmp_b};      // RULE25

    // Accumulators step on every pulse clock
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            acc_a_q <= 16'h0000;
            acc_b_q <= 16'h0000;
            sd_a_q  <= 1'b0;
            sd_b_q  <= 1'b0;
        end else if (wr_ctrl) begin
            acc_a_q <= 16'h0000;
            acc_b_q <= 16'h0000;
            sd_a_q  <= 1'b0;
            sd_b_q  <= 1'b0;
        end else if (tick) begin
            acc_a_q <= sum_a[15:0];                                 // RULE12
            acc_b_q <= sum_b[15:0];                                 // RULE12
            sd_a_q  <= sum_a[16];                                   // RULE13
            sd_b_q  <= sum_b[16];                                   // RULE13
        end
    end

    // ------------------------------------------------------------------
    // Return-to-zero phase
    // ------------------------------------------------------------------
    // High in the first half of each pulse clock. With divide-by-one no
    // half period exists on clk, so the whole clock stays high there.
    wire logic rz_first_half = (mask == pdg_pkg::MASK_1) |
                               (phase <= (mask >> 1));              // RULE18 RULE19

    // ------------------------------------------------------------------
    // Output levels per mode
    // ------------------------------------------------------------------
    wire logic [7:0] cnt8  = cnt_q[7:0];
    wire logic [7:0] cnt28 = cnt2_q[7:0];

    logic lvl_a;
    logic lvl_b;
    always_comb begin
        lvl_a = 1'b0;
        lvl_b = 1'b0;
        unique case (mode)
            pdg_pkg::MODE_SINGLE: begin
                lvl_b = (cnt_q < cmp_a);                            // RULE3
            end
            pdg_pkg::MODE_TWIN8: begin
                lvl_a = (cnt8 < cmpa_lo_q);                         // RULE5
                lvl_b = (cnt8 >= cmpb_hi_q) &
                        (cnt8 < cmpa_hi_q);                         // RULE6 RULE7
            end
            pdg_pkg::MODE_TWIN16: begin
                lvl_a = (cnt_q < cmp_a);                            // RULE9 RULE11
                lvl_b = (cnt_q < cmp_b);                            // RULE10 RULE11
            end
            pdg_pkg::MODE_NRZ: begin
                lvl_a = sd_a_q;                                     // RULE13
                lvl_b = sd_b_q;                                     // RULE13
            end
            pdg_pkg::MODE_DUAL8: begin
                lvl_a = (cnt8 < cmpa_lo_q);                         // RULE15
                lvl_b = (cnt28 < cmpa_hi_q);                        // RULE15
            end
            pdg_pkg::MODE_RZ: begin
                lvl_a = sd_a_q & rz_first_half;                     // RULE17
                lvl_b = sd_b_q & rz_first_half;                     // RULE17
            end
            default: begin
                lvl_a = 1'b0;                                       // RULE1
                lvl_b = 1'b0;
            end
        endcase
    end

    // Pin ownership: A only in the two-output modes, B in every live mode
    wire logic drv_a = m_twin8 | m_twin16 | m_nrz | m_dual8 | m_rz; // RULE1
    wire logic drv_b = drv_a | m_single;                            // RULE1

    // Registered pin drive, one clock after the counter state
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out_a_q <= 1'b0;
            out_b_q <= 1'b0;
            oe_a_q  <= 1'b0;
            oe_b_q  <= 1'b0;
        end else begin
            out_a_q <= lvl_a & drv_a;
            out_b_q <= lvl_b & drv_b;
            oe_a_q  <= drv_a;                                       // RULE1
            oe_b_q  <= drv_b;                                       // RULE1
        end
    end

    assign pulse_output_a_pin_o  = out_a_q;
    assign pulse_output_a_pin_oe = oe_a_q;
    assign pulse_output_b_pin_o  = out_b_q;
    assign pulse_output_b_pin_oe = oe_b_q;

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= pdg_pkg::CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= wr_byte;
        end
    end

    // ------------------------------------------------------------------
    // Compare registers with hidden low-byte holding
    // ------------------------------------------------------------------
    // Low writes park in the holding byte; outside the byte-wide modes the high write commits both so
    // the counter never sees a half-updated 16-bit value.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_a_q  <= pdg_pkg::CMP_RST;
            cmpa_lo_q <= pdg_pkg::CMP_RST;
            cmpa_hi_q <= pdg_pkg::CMP_RST;
        end else if (wr_a_lo) begin
            hold_a_q <= wr_byte;                                    // RULE22
            if (m_byte) begin
                cmpa_lo_q <= wr_byte;
            end
        end else if (wr_a_hi) begin
            cmpa_hi_q <= wr_byte;                                   // RULE22
            if (!m_byte) begin
                cmpa_lo_q <= hold_a_q;                              // RULE22
            end
        end
    end

    // Same scheme for the second pair
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_b_q  <= pdg_pkg::CMP_RST;
            cmpb_lo_q <= pdg_pkg::CMP_RST;
            cmpb_hi_q <= pdg_pkg::CMP_RST;
        end else if (wr_b_lo) begin
            hold_b_q <= wr_byte;                                    // RULE22
            if (m_byte) begin
                cmpb_lo_q <= wr_byte;
            end
        end else if (wr_b_hi) begin
            cmpb_hi_q <= wr_byte;                                   // RULE22
            if (!m_byte) begin
                cmpb_lo_q <= hold_b_q;                              // RULE22
            end
        end
    end

    // ------------------------------------------------------------------
    // Read-back
    // ------------------------------------------------------------------
    // Status shows live counter and pin levels; unmapped reads return zero
    wire logic [31:0] status_w = {14'h0000, out_b_q, out_a_q, cnt_q};

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (addr_w)
            pdg_pkg::ADDR_CTRL:    rd_mux = {24'h000000, ctrl_q};
            pdg_pkg::ADDR_CMPA_LO: rd_mux = {24'h000000, cmpa_lo_q};
            pdg_pkg::ADDR_CMPA_HI: rd_mux = {24'h000000, cmpa_hi_q};
            pdg_pkg::ADDR_CMPB_LO: rd_mux = {24'h000000, cmpb_lo_q};
            pdg_pkg::ADDR_CMPB_HI: rd_mux = {24'h000000, cmpb_hi_q};
            pdg_pkg::ADDR_STATUS:  rd_mux = status_w;
            default:               rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data captured in the wait cycle, released one cycle later
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_ack_q   <= 1'b0;
            readdata_q <= 32'h0000_0000;
        end else begin
            rd_ack_q <= rd_start;
            if (rd_start) begin
                readdata_q <= rd_mux;
            end
        end
    end

endmodule

// ### verification/pdg_pulse_gen_assertions.sv
// Checks on pulse pins and bus timing.
// Assumes pdg_pkg compiled first; bound below.
`timescale 1ns/100ps
module pdg_checker #(parameter int ADDR_W = 5) (
    // Clock, reset and register bus
    input wire logic              clk,
    input wire logic              rst_b,
    input wire logic [ADDR_W-1:0] address,
    input wire logic              read,
    input wire logic              write,
    input wire logic [31:0]       writedata,
    input wire logic [3:0]        byteenable,
    input wire logic [31:0]       readdata,
    input wire logic              waitrequest,
    // Pulse pins
    input wire logic              pa,
    input wire logic              oa,
    input wire logic              pb,
    input wire logic              ob
);
    logic [7:0]  ctrl_q, hold_q, bhi_q;
    logic [15:0] cmpa_q;
    // Pins lag one clock, so checks wait for a settled mode
    wire       wr0 = write && byteenable[0];
    wire       ctl_wr = wr0 && address == ADDR_W'(pdg_pkg::ADDR_CTRL);
    wire [2:0] md = ctrl_q[6:4];
    wire       off = (md == pdg_pkg::MODE_OFF) || (md == 3'h7);
    wire       nrz = ctrl_q[6:2] == {pdg_pkg::MODE_NRZ, pdg_pkg::DIV_1} && cmpa_q == 16'h8000;
    wire       rz4 = ctrl_q[6:2] == {pdg_pkg::MODE_RZ, pdg_pkg::DIV_4};
    // Shadow of control and committed compares
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= 8'h00;
            hold_q <= 8'h00;
            bhi_q  <= 8'h00;
            cmpa_q <= 16'h0000;
        end else if (wr0) begin
            if (ctl_wr) ctrl_q <= writedata[7:0];
            if (address == ADDR_W'(pdg_pkg::ADDR_CMPA_LO)) hold_q <= writedata[7:0];
            if (address == ADDR_W'(pdg_pkg::ADDR_CMPA_HI)) cmpa_q <= {writedata[7:0], hold_q};
            if (address == ADDR_W'(pdg_pkg::ADDR_CMPB_HI)) bhi_q <= writedata[7:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    off_release_a: assert property (off[*3] |-> !oa && !ob)
        else $error("pin driven in off mode");
    off_low_a: assert property (off[*3] |-> !pa && !pb)
        else $error("pin high in off mode");
    single_only_b_a: assert property ((md == pdg_pkg::MODE_SINGLE)[*3] |-> !oa && ob)
        else $error("single mode enables wrong");
    modes_drive_a: assert property ((md >= 3'h2 && md <= 3'h6)[*3] |-> oa && ob)
        else $error("pin not driven");
    twin16_start_a: assert property (ctl_wr && cmpa_q[15:8] != 8'h00
        && writedata[6:2] == {pdg_pkg::MODE_TWIN16, pdg_pkg::DIV_1} |-> ##2 pa[*8])
        else $error("twin16 A low after restart");
    twin8_sync_a: assert property ((md == pdg_pkg::MODE_TWIN8)[*3] ##0
        (bhi_q == 8'h00 && cmpa_q[15:8] != 8'h00 && $rose(pa)) |-> pb)
        else $error("twin8 outputs not in step");
    rz_pulse_a: assert property (rz4[*3] ##0 $rose(pa) |-> ##1 pa ##1 !pa)
        else $error("RZ pulse not two clocks");
    nrz_fresh_a: assert property (nrz[*5] |-> pa != $past(pa))
        else $error("NRZ half scale not toggling");
    write_nowait_a: assert property (ctl_wr |-> !waitrequest)
        else $error("control write stalled");
    cover property (rz4 && $rose(pa));
    cover property (nrz[*5]);
    cover property (md == pdg_pkg::MODE_TWIN8 && $rose(pa) && pb);
endmodule

bind pdg_pulse_gen pdg_checker #(.ADDR_W(ADDR_W)) u_pdg_chk (
    .clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .pa(pulse_output_a_pin_o), .oa(pulse_output_a_pin_oe),
    .pb(pulse_output_b_pin_o), .ob(pulse_output_b_pin_oe));

// ### verification/pdg_pulse_gen_tb_top.sv
// Bench: pin high time per window against a model.
// Assumes pdg_pkg and the checker compiled first.
`timescale 1ns/100ps
module pdg_pulse_gen_tb_top;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [4:0]  address = 5'h00;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [3:0]  byteenable = 4'hF;
    logic [31:0] readdata, q;
    logic        waitrequest, pa, oa, pb, ob, lp;
    logic [31:0] rs = 32'h0000_9B58;
    int          n_mismatch = 0;
    int          total_checks = 0;
    int          ha, hb, ea, eb, ra, al, ah, bl, bh, p, p2;

    always #5 clk = ~clk;

    pdg_pulse_gen uut (.clk(clk), .rst_b(rst_b), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .pulse_output_a_pin_o(pa),
        .pulse_output_a_pin_oe(oa), .pulse_output_b_pin_o(pb), .pulse_output_b_pin_oe(ob));

    // Xorshift source
    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction

    // High clocks per period, capped at the period
    function automatic int hi(int c, int n);
        return (c < n) ? c : n;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // One transfer, held until waitrequest is seen low at a rising edge
    task automatic rw(input logic wr, input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        read <= ~wr;
        write <= wr;
        address <= a;
        writedata <= {24'h0, d};
        do @(posedge clk);
        while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    // Program compares with mode off, start, count pin time
    task automatic run(input logic [7:0] c, input logic [15:0] a, input logic [15:0] b,
                       input int s, input int n, input int xa, input int xb,
                       input int xea, input int xeb);
        rw(1'b1, pdg_pkg::ADDR_CTRL, 8'h00);
        rw(1'b1, pdg_pkg::ADDR_CMPA_LO, a[7:0]);
        rw(1'b1, pdg_pkg::ADDR_CMPA_HI, a[15:8]);
        rw(1'b1, pdg_pkg::ADDR_CMPB_LO, b[7:0]);
        rw(1'b1, pdg_pkg::ADDR_CMPB_HI, b[15:8]);
        rw(1'b1, pdg_pkg::ADDR_CTRL, c);
        repeat (s) @(posedge clk);
        {ha, hb, ea, eb, ra} = '0;
        lp = pa;
        repeat (n) begin
            @(negedge clk);
            ha += int'(pa === 1'b1);
            hb += int'(pb === 1'b1);
            ea += int'(oa === 1'b1);
            eb += int'(ob === 1'b1);
            ra += int'(pa === 1'b1 && lp !== 1'b1);
            lp = pa;
        end
        if (xa >= 0) check(ha, xa);
        check(hb, xb);
        if (xea >= 0) check(ea, xea);
        if (xeb >= 0) check(eb, xeb);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        stop_test();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        rw(1'b0, pdg_pkg::ADDR_CTRL, 8'h00);
        check(q, {24'h00_0000, pdg_pkg::CTRL_RST});
        rw(1'b0, 5'h18, 8'h00);
        check(q, 32'h0000_0000);
        run(8'h00, 16'h0003, 16'h0007, 4, 16, 0, 0, 0, 0);
        run(8'h70, 16'h0003, 16'h0007, 4, 16, 0, 0, 0, 0);
        run(8'h10, 16'h0005, 16'h0009, 4, 100, -1, 50, 0, 100);
        // Low byte held until the high write
        rw(1'b1, pdg_pkg::ADDR_CMPA_LO, 8'h77);
        rw(1'b0, pdg_pkg::ADDR_CMPA_LO, 8'h00);
        check(q, 32'h0000_0005);
        rw(1'b1, pdg_pkg::ADDR_CMPA_HI, 8'h00);
        rw(1'b0, pdg_pkg::ADDR_CMPA_LO, 8'h00);
        check(q, 32'h0000_0077);
        // Same duty, fewer periods per divider
        for (int d = 0; d < 4; d++) begin
            run({4'h2, d[1:0], 2'h0}, 16'h0603, 16'h0007, 4, 512, 192, 384, 512, 512);
            check(ra, 512 / (8 << (2 * d)));
        end
        // Random twin8 and dual8 over whole periods
        for (int i = 0; i < 6; i++) begin
            al = int'(rnd() % 16);
            ah = int'(rnd() % 16);
            bl = 3 + int'(rnd() % 13);
            bh = int'(rnd() % 16);
            p = bl + 1;
            p2 = bh + 1;
            if (i % 2 == 1) run(8'h50, {ah[7:0], al[7:0]}, {bh[7:0], bl[7:0]}, 4, 2 * p * p2,
                2 * p2 * hi(al, p), 2 * p * hi(ah, p2), -1, -1);
            else run(8'h20, {ah[7:0], al[7:0]}, {bh[7:0], bl[7:0]}, 4, 2 * p * p2,
                2 * p2 * hi(al, p), 2 * p2 * ((hi(ah, p) > bh) ? hi(ah, p) - bh : 0),
                -1, -1);
        end
        run(8'h30, 16'h0102, 16'h0005, 0, 300, 258, 5, -1, -1);
        run(8'h40, 16'h8000, 16'hC000, 8, 64, 32, 48, 64, 64);
        run(8'h64, 16'h4000, 16'h8000, 8, 64, 8, 16, 64, 64);
        // Lane 0 off: control byte kept
        byteenable <= 4'hE;
        rw(1'b1, pdg_pkg::ADDR_CTRL, 8'h30);
        byteenable <= 4'hF;
        rw(1'b0, pdg_pkg::ADDR_CTRL, 8'h00);
        check(q, 32'h0000_0064);
        stop_test();
    end
endmodule
